// [rtl/bififo_consts.svh]
// Constants for the bidirectional queue port controller.
`ifndef BIFIFO_CONSTS_SVH
`define BIFIFO_CONSTS_SVH

`define QUEUE_ADDR_W 6
`define OFFSET_W 6
`define LANE_W 9
`define LANE_COUNT 4
`define REG_OFFSET_TABLE 4'h0
`define REG_STATUS 4'h4
`define REG_LEVELS 4'h8
`define OFFSET_TABLE_RST 24'h810204
`define ST_A_FLAGS_LSB 0
`define ST_B_FLAGS_LSB 4
`define ST_MAIL_LSB 8
`define ST_PRESET_LSB 10
`define LV_A2B_LSB 0
`define LV_B2A_LSB 16

`endif

// [rtl/bififo_pkg.sv]
// Types shared by the bidirectional queue port controller.
package bififo_pkg;
  typedef logic [35:0] word_t;
  typedef logic [5:0] offset_t;
  typedef logic [31:0] bus_word_t;
endpackage

// [rtl/bidir_fifo_port_ctrl.sv]
// Port control of a bidirectional queue pair with mailboxes and parity.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bififo_consts.svh"

// Behaviour
// - Port B empty flag low while A-to-B queue empty; rises second B edge.
// - A port acts on its clock edge only with its enable high.
// - Port A full flag low when A-to-B queue full; writes then ignored.
// - Full flags low in reset; high on second own-port edge after release.
// - Port B full flag low when B-to-A queue full; writes then ignored.
// - Offset preset select captured at reset release; picks one of four offsets.
// - Port A mailbox select picks B-to-A mailbox, else B-to-A queue output.
// - Port B mailbox select picks A-to-B mailbox, else A-to-B queue output.
// - Port A mailbox write drops A-to-B mail flag; writes blocked while low.
// - A-to-B mail flag rises on port B mailbox read; high after reset.
// - Port B mailbox write drops B-to-A mail flag; writes blocked while low.
// - B-to-A mail flag rises on port A mailbox read; high after reset.
// - Parity sense input picks odd or even for checking and generation.
// - Port A parity error low when any 9-bit lane fails parity.
// - Port A parity error forced high during mailbox read with generation.
// - Port B parity error low when any 9-bit lane fails parity.
// - Port B parity error forced high during mailbox read with generation.
// - Port A reads carry generated parity in each lane's top bit.
// - Port B reads carry generated parity in each lane's top bit.
// - Reset sets nearly-full, parity error and mail flags high, others low.
// - Write-not-read selects write or read; outputs float while it is high.
// - Port A empty flag low while B-to-A queue empty; rises second A edge.
// - Select must be low to transfer; outputs float while it is high.
// - Nearly-empty flag low while word count is at most the offset.
// - Nearly-full flag low while free locations are at most the offset.
module bidir_fifo_port_ctrl
  import bififo_pkg::*;
#(
  parameter int unsigned ADDR_W = `QUEUE_ADDR_W
) (
  // System clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Port A control.
  input wire logic porta_clock,
  input wire logic porta_select_n,
  input wire logic porta_xfer_enable,
  input wire logic porta_write_not_read,
  input wire logic porta_mailbox_choose,
  input wire logic porta_parity_gen_on,
  // Port A data pins.
  input wire logic [35:0] porta_data_bus_in,
  output logic [35:0] porta_data_bus_out,
  output logic porta_data_bus_oe,
  // Port A flags.
  output logic porta_queue_empty_n,
  output logic porta_queue_full_n,
  output logic porta_nearly_empty_n,
  output logic porta_nearly_full_n,
  output logic porta_parity_error_n,
  // Port B control.
  input wire logic portb_clock,
  input wire logic portb_select_n,
  input wire logic portb_xfer_enable,
  input wire logic portb_write_not_read,
  input wire logic portb_mailbox_choose,
  input wire logic portb_parity_gen_on,
  // Port B data pins.
  input wire logic [35:0] portb_data_bus_in,
  output logic [35:0] portb_data_bus_out,
  output logic portb_data_bus_oe,
  // Port B flags.
  output logic portb_queue_empty_n,
  output logic portb_queue_full_n,
  output logic portb_nearly_empty_n,
  output logic portb_nearly_full_n,
  output logic portb_parity_error_n,
  // Shared controls and mail flags.
  input wire logic [1:0] offset_preset_select,
  input wire logic odd_parity_sense,
  output logic a_to_b_mail_waiting_n,
  output logic b_to_a_mail_waiting_n,
  // Avalon-MM register slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ==========================================================================
  // Port signal arrays, index 0 is port A and 1 is port B.
  localparam logic [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};

  logic [1:0] pclk;
  logic [1:0] sel_n;
  logic [1:0] en;
  logic [1:0] wnr;
  logic [1:0] mb;
  logic [1:0] pgen;
  logic [1:0] pclk_q;
  logic [1:0] pedge;
  logic [1:0] acc;
  word_t din [2];
  word_t mbox_w [2];
  word_t outreg_w [2];
  word_t dout_w [2];
  logic [1:0] oe_w;
  logic [1:0] perr_n_w;
  logic [1:0] full_n;
  logic [1:0] nfull_n;
  logic [1:0] empty_n;
  logic [1:0] nempty_n;
  logic [1:0] mail_n;
  logic [ADDR_W:0] level_w [2];
  logic reset_q;
  logic [1:0] preset_q;
  logic [23:0] offset_table_q;
  offset_t offset_sel;

  assign pclk = {portb_clock, porta_clock};
  assign sel_n = {portb_select_n, porta_select_n};
  assign en = {portb_xfer_enable, porta_xfer_enable};
  assign wnr = {portb_write_not_read, porta_write_not_read};
  assign mb = {portb_mailbox_choose, porta_mailbox_choose};
  assign pgen = {portb_parity_gen_on, porta_parity_gen_on};
  assign din[0] = porta_data_bus_in;
  assign din[1] = portb_data_bus_in;

  // ==========================================================================
  // Port clock edge detection and offset preset capture.
  always_ff @(posedge clk) begin
    if (reset) begin
      pclk_q <= 2'h3;
    end else begin
      pclk_q <= pclk;
    end
  end

  always_ff @(posedge clk) begin
    reset_q <= reset;
    if (reset_q && !reset) begin
      preset_q <= offset_preset_select;
    end
  end

  always_comb begin
    case (preset_q)
      2'h0: offset_sel = offset_table_q[5:0];
      2'h1: offset_sel = offset_table_q[11:6];
      2'h2: offset_sel = offset_table_q[17:12];
      default: offset_sel = offset_table_q[23:18];
    endcase
  end

  // ==========================================================================
  // Per-port access decode, read data path and parity.
  for (genvar p = 0; p < 2; p++) begin : g_port
    word_t src, gen_word, dout_q;
    logic [3:0] lane_ok;
    logic oe_q, perr_n_q;

    assign pedge[p] = pclk[p] & ~pclk_q[p];
    assign acc[p] = pedge[p] & en[p] & ~sel_n[p];
    assign src = mb[p] ? mbox_w[1-p] : outreg_w[1-p];

    for (genvar l = 0; l < `LANE_COUNT; l++) begin : g_lane
      assign lane_ok[l] = (^din[p][`LANE_W*l +: `LANE_W]) == odd_parity_sense;
      assign gen_word[`LANE_W*l +: `LANE_W] =
        {(^src[`LANE_W*l +: 8]) ^ odd_parity_sense, src[`LANE_W*l +: 8]};
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        oe_q <= 1'b0;
        dout_q <= '0;
        perr_n_q <= 1'b1;
      end else begin
        oe_q <= ~sel_n[p] & ~wnr[p];
        dout_q <= pgen[p] ? gen_word : src;
        perr_n_q <= (~wnr[p] & mb[p] & pgen[p]) | (&lane_ok);
      end
    end

    assign dout_w[p] = dout_q;
    assign oe_w[p] = oe_q;
    assign perr_n_w[p] = perr_n_q;
  end

  // ==========================================================================
  // Queue g is written by port g and read by the other port.
  for (genvar g = 0; g < 2; g++) begin : g_queue
    localparam int R = 1 - g;
    word_t mem [DEPTH];
    word_t outreg_q, mbox_q;
    logic [ADDR_W:0] wptr_q, rptr_q, wptr_d, rptr_d;
    logic [ADDR_W:0] rptr_seen_q, wptr_seen_q, wused, rused;
    logic live_q, full_n_q, nfull_n_q, empty_n_q, nempty_n_q, mail_n_q;
    logic q_wr, q_rd, mb_wr, mb_rd;

    assign q_wr = acc[g] & wnr[g] & ~mb[g] & full_n_q;
    assign q_rd = acc[R] & ~wnr[R] & ~mb[R] & empty_n_q;
    assign mb_wr = acc[g] & wnr[g] & mb[g] & mail_n_q;
    assign mb_rd = acc[R] & ~wnr[R] & mb[R];
    assign wptr_d = wptr_q + {{ADDR_W{1'b0}}, q_wr};
    assign rptr_d = rptr_q + {{ADDR_W{1'b0}}, q_rd};
    assign wused = wptr_d - rptr_seen_q;
    assign rused = wptr_seen_q - rptr_d;

    // Storage and write pointer.
    always_ff @(posedge clk) begin
      if (q_wr) begin
        mem[wptr_q[ADDR_W-1:0]] <= din[g];
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        wptr_q <= '0;
      end else begin
        wptr_q <= wptr_d;
      end
    end

    // Read pointer and output register.
    always_ff @(posedge clk) begin
      if (reset) begin
        rptr_q <= '0;
        outreg_q <= '0;
      end else if (q_rd) begin
        rptr_q <= rptr_d;
        outreg_q <= mem[rptr_q[ADDR_W-1:0]];
      end
    end

    // Writer-side flags, clocked by the writing port.
    always_ff @(posedge clk) begin
      if (reset) begin
        rptr_seen_q <= '0;
        live_q <= 1'b0;
        full_n_q <= 1'b0;
        nfull_n_q <= 1'b1;
      end else if (pedge[g]) begin
        rptr_seen_q <= rptr_q;
        live_q <= 1'b1;
        full_n_q <= live_q & (wused != DEPTH);
        nfull_n_q <= (DEPTH - wused) > (ADDR_W+1)'(offset_sel);
      end
    end

    // Reader-side flags, clocked by the reading port.
    always_ff @(posedge clk) begin
      if (reset) begin
        wptr_seen_q <= '0;
        empty_n_q <= 1'b0;
        nempty_n_q <= 1'b0;
      end else if (pedge[R]) begin
        wptr_seen_q <= wptr_q;
        empty_n_q <= wptr_seen_q != rptr_d;
        nempty_n_q <= rused > (ADDR_W+1)'(offset_sel);
      end
    end

    // Mailbox; a write in the same cycle as a read leaves the flag low.
    always_ff @(posedge clk) begin
      if (reset) begin
        mbox_q <= '0;
        mail_n_q <= 1'b1;
      end else begin
        if (mb_wr) begin
          mbox_q <= din[g];
          mail_n_q <= 1'b0;
        end else if (mb_rd) begin
          mail_n_q <= 1'b1;
        end
      end
    end

    assign mbox_w[g] = mbox_q;
    assign outreg_w[g] = outreg_q;
    assign full_n[g] = full_n_q;
    assign nfull_n[g] = nfull_n_q;
    assign empty_n[R] = empty_n_q;
    assign nempty_n[R] = nempty_n_q;
    assign mail_n[g] = mail_n_q;
    assign level_w[g] = wptr_q - rptr_seen_q;
  end

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then the answer.
  logic req;
  logic wait_q;
  bus_word_t rdata_q, rd_mux;
  logic [3:0] a_flags;
  logic [3:0] b_flags;

  assign req = avs_read | avs_write;
  assign a_flags = {nfull_n[0], nempty_n[0], full_n[0], empty_n[0]};
  assign b_flags = {nfull_n[1], nempty_n[1], full_n[1], empty_n[1]};

  always_ff @(posedge clk) begin
    if (reset) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      offset_table_q <= `OFFSET_TABLE_RST;
    end else if (avs_write && !wait_q && avs_address == `REG_OFFSET_TABLE) begin
      for (int i = 0; i < 3; i++) begin
        if (avs_byteenable[i]) begin
          offset_table_q[8*i +: 8] <= avs_writedata[8*i +: 8];
        end
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    case (avs_address)
      `REG_OFFSET_TABLE: begin
        rd_mux[23:0] = offset_table_q;
      end
      `REG_STATUS: begin
        rd_mux[`ST_A_FLAGS_LSB +: 4] = a_flags;
        rd_mux[`ST_B_FLAGS_LSB +: 4] = b_flags;
        rd_mux[`ST_MAIL_LSB +: 2] = mail_n;
        rd_mux[`ST_PRESET_LSB +: 2] = preset_q;
      end
      `REG_LEVELS: begin
        rd_mux[`LV_A2B_LSB +: 16] = 16'(level_w[0]);
        rd_mux[`LV_B2A_LSB +: 16] = 16'(level_w[1]);
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (avs_read && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  // ==========================================================================
  // Outputs.
  assign porta_data_bus_out = dout_w[0];
  assign porta_data_bus_oe = oe_w[0];
  assign porta_parity_error_n = perr_n_w[0];
  assign porta_queue_empty_n = empty_n[0];
  assign porta_queue_full_n = full_n[0];
  assign porta_nearly_empty_n = nempty_n[0];
  assign porta_nearly_full_n = nfull_n[0];
  assign portb_data_bus_out = dout_w[1];
  assign portb_data_bus_oe = oe_w[1];
  assign portb_parity_error_n = perr_n_w[1];
  assign portb_queue_empty_n = empty_n[1];
  assign portb_queue_full_n = full_n[1];
  assign portb_nearly_empty_n = nempty_n[1];
  assign portb_nearly_full_n = nfull_n[1];
  assign a_to_b_mail_waiting_n = mail_n[0];
  assign b_to_a_mail_waiting_n = mail_n[1];
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule // bidir_fifo_port_ctrl
`default_nettype wire

// [testbench/bififo_props.sv]
// Checker bound to the port controller pins.
`timescale 1ns/1ps
`default_nettype none
module bififo_props
  import bififo_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Port A.
  input wire logic porta_clock,
  input wire logic porta_select_n,
  input wire logic porta_xfer_enable,
  input wire logic porta_write_not_read,
  input wire logic porta_mailbox_choose,
  input wire logic porta_parity_gen_on,
  input wire logic [35:0] porta_data_bus_in,
  input wire logic porta_data_bus_oe,
  input wire logic porta_queue_empty_n,
  input wire logic porta_queue_full_n,
  input wire logic porta_nearly_empty_n,
  input wire logic porta_nearly_full_n,
  input wire logic porta_parity_error_n,
  // Port B.
  input wire logic portb_clock,
  input wire logic portb_select_n,
  input wire logic portb_xfer_enable,
  input wire logic portb_write_not_read,
  input wire logic portb_mailbox_choose,
  input wire logic portb_parity_gen_on,
  input wire logic portb_data_bus_oe,
  input wire logic portb_queue_full_n,
  input wire logic portb_parity_error_n,
  // Shared.
  input wire logic odd_parity_sense,
  input wire logic a_to_b_mail_waiting_n,
  input wire logic b_to_a_mail_waiting_n,
  input wire logic avs_read,
  input wire logic avs_waitrequest
);
  logic pa_q, pb_q, ok_a, wra, rdb, drv_a, drv_b, gfa, gfb;
  // ====
  // Edge, drive and parity helpers.
  always_ff @(posedge clk) begin
    pa_q <= porta_clock;
    pb_q <= portb_clock;
  end
  always_comb begin
    ok_a = 1'b1;
    for (int k = 0; k < 4; k++)
      if ((^porta_data_bus_in[9*k +: 9]) != odd_parity_sense) ok_a = 1'b0;
  end
  assign wra = porta_clock && !pa_q && !porta_select_n && porta_xfer_enable
    && porta_write_not_read && porta_mailbox_choose;
  assign rdb = portb_clock && !pb_q && !portb_select_n && portb_xfer_enable
    && !portb_write_not_read && portb_mailbox_choose;
  assign drv_a = !porta_select_n && !porta_write_not_read;
  assign drv_b = !portb_select_n && !portb_write_not_read;
  assign gfa = !porta_write_not_read && porta_mailbox_choose
    && porta_parity_gen_on;
  assign gfb = !portb_write_not_read && portb_mailbox_choose
    && portb_parity_gen_on;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ====
  // Properties.
  a_reset_flags:
  assert property ($past(reset) |-> !porta_queue_full_n && !portb_queue_full_n
    && !porta_queue_empty_n && !porta_nearly_empty_n && porta_nearly_full_n
    && a_to_b_mail_waiting_n && b_to_a_mail_waiting_n)
    else $error("flags wrong after reset");
  a_drive_a:
  assert property (1'b1 |=> porta_data_bus_oe == $past(drv_a))
    else $error("port A drive wrong");
  a_drive_b:
  assert property (1'b1 |=> portb_data_bus_oe == $past(drv_b))
    else $error("port B drive wrong");
  a_pgen_a:
  assert property (gfa |=> porta_parity_error_n)
    else $error("port A parity error not forced");
  a_pgen_b:
  assert property (gfb |=> portb_parity_error_n)
    else $error("port B parity error not forced");
  a_check_a:
  assert property (!gfa |=> porta_parity_error_n == $past(ok_a))
    else $error("port A parity check wrong");
  a_mail_set:
  assert property (wra && !rdb |-> ##[1:3] !a_to_b_mail_waiting_n)
    else $error("mail flag not lowered");
  a_mail_clr:
  assert property (rdb && !wra |-> ##[1:3] a_to_b_mail_waiting_n)
    else $error("mail flag not raised");
  a_bus_answer:
  assert property ($rose(avs_read) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
endmodule // bififo_props
bind bidir_fifo_port_ctrl bififo_props u_bififo_props (.*);
`default_nettype wire

// [testbench/port_clock_src.sv]
// Far-side free-running port clocks.
`timescale 1ns/1ps
`default_nettype none
module port_clock_src (
  // System clock.
  input wire logic clk,
  // Port clocks.
  output logic porta_clock,
  output logic portb_clock
);
  logic [1:0] ca_q = 2'h0;
  logic [2:0] cb_q = 3'h0;
  // ====
  // Port A runs at a quarter and port B at a sixth of clk.
  always_ff @(posedge clk) begin
    ca_q <= ca_q + 2'h1;
    cb_q <= (cb_q == 3'h5) ? 3'h0 : cb_q + 3'h1;
  end
  assign porta_clock = ca_q[1];
  assign portb_clock = (cb_q > 3'h2);
endmodule // port_clock_src
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the port controller.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import bififo_pkg::*;
;
  logic clk, reset, porta_clock, portb_clock;
  logic porta_select_n, porta_xfer_enable, porta_write_not_read;
  logic porta_mailbox_choose, porta_parity_gen_on, porta_data_bus_oe;
  logic portb_select_n, portb_xfer_enable, portb_write_not_read;
  logic portb_mailbox_choose, portb_parity_gen_on, portb_data_bus_oe;
  word_t porta_data_bus_in, porta_data_bus_out, mv;
  word_t portb_data_bus_in, portb_data_bus_out;
  logic porta_queue_empty_n, porta_queue_full_n, porta_parity_error_n;
  logic porta_nearly_empty_n, porta_nearly_full_n;
  logic portb_queue_empty_n, portb_queue_full_n, portb_parity_error_n;
  logic portb_nearly_empty_n, portb_nearly_full_n;
  logic [1:0] offset_preset_select;
  logic odd_parity_sense, a_to_b_mail_waiting_n, b_to_a_mail_waiting_n;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest;
  bus_word_t avs_writedata, avs_readdata, rd;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  bidir_fifo_port_ctrl u_bidir_fifo_port_ctrl (.*);
  port_clock_src u_port_clock_src (.*);
  // ====
  // Tasks.
  task automatic wrap_up();
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input word_t got, input word_t exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic word_t par(input word_t w, input bit odd);
    for (int k = 0; k < 4; k++) w[9*k+8] = (^w[9*k +: 8]) ^ odd;
    return w;
  endfunction
  task automatic bus(input bit wr, input logic [3:0] a, input bus_word_t d);
    @(posedge clk);
    {avs_address, avs_writedata, avs_byteenable} <= {a, d, 4'hf};
    {avs_write, avs_read} <= {wr, !wr};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
  endtask
  task automatic op(input bit p, input bit wr, input bit mb, input bit pg,
                    input word_t d);
    while ((p ? portb_clock : porta_clock) !== 1'b0) @(posedge clk);
    if (p) begin
      {portb_select_n, portb_xfer_enable} <= 2'b01;
      {portb_write_not_read, portb_mailbox_choose, portb_parity_gen_on} <=
        {wr, mb, pg};
      portb_data_bus_in <= d;
    end else begin
      {porta_select_n, porta_xfer_enable} <= 2'b01;
      {porta_write_not_read, porta_mailbox_choose, porta_parity_gen_on} <=
        {wr, mb, pg};
      porta_data_bus_in <= d;
    end
    while ((p ? portb_clock : porta_clock) !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    {porta_select_n, portb_select_n, porta_xfer_enable, portb_xfer_enable} <=
      4'hc;
    repeat (3) @(posedge clk);
  endtask
  // ====
  // Clock, timeout and tests.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    reset = 1'b1;
    {porta_select_n, portb_select_n, porta_xfer_enable, portb_xfer_enable} =
      4'hc;
    {porta_write_not_read, porta_mailbox_choose, porta_parity_gen_on} = 3'h0;
    {portb_write_not_read, portb_mailbox_choose, portb_parity_gen_on} = 3'h0;
    {porta_data_bus_in, portb_data_bus_in} = '0;
    {offset_preset_select, odd_parity_sense} = 3'h3;
    {avs_read, avs_write, avs_address, avs_byteenable} = 10'h0;
    avs_writedata = '0;
    repeat (26) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    chk(word_t'({portb_nearly_full_n, porta_nearly_empty_n}), 36'h2);
    offset_preset_select <= 2'h2;
    bus(0, 4'h0, '0);
    chk(word_t'(rd), 36'h810204);
    bus(1, 4'h0, 32'hff810205);
    bus(0, 4'h0, '0);
    chk(word_t'(rd), 36'h810205);
    bus(1, 4'hc, 32'hffffffff);
    bus(0, 4'hc, '0);
    chk(word_t'(rd), 36'h0);
    for (int i = 0; i < 65; i++) begin
      op(0, 1, 0, 0, word_t'(36'h912345678 ^ i));
      if (i == 54) chk(word_t'(porta_nearly_full_n), 36'h1);
      if (i == 55) chk(word_t'(porta_nearly_full_n), 36'h0);
      if (i == 63) chk(word_t'(porta_queue_full_n), 36'h0);
    end
    bus(0, 4'h8, '0);
    chk(word_t'(rd[15:0]), 36'h40);
    chk(word_t'(portb_queue_empty_n), 36'h1);
    chk(word_t'(portb_nearly_empty_n), 36'h1);
    for (int i = 0; i < 65; i++) begin
      op(1, 0, 0, 0, '0);
      chk(portb_data_bus_out, word_t'(36'h912345678 ^ (i > 63 ? 63 : i)));
    end
    chk(word_t'(portb_queue_empty_n), 36'h0);
    chk(word_t'(portb_nearly_empty_n), 36'h0);
    for (int s = 0; s < 2; s++) begin
      odd_parity_sense <= s[0];
      op(1, 1, 0, 0, word_t'(36'h3c0f00ff1 + s));
      chk(word_t'(portb_queue_full_n), 36'h1);
      repeat (12) @(posedge clk);
      chk(word_t'(porta_queue_empty_n), 36'h1);
      op(0, 0, 0, 1, '0);
      chk(porta_data_bus_out, par(word_t'(36'h3c0f00ff1 + s), s[0]));
    end
    for (int p = 0; p < 2; p++) begin
      mv = word_t'(36'h5a5a5a5a5 ^ p);
      op(p[0], 1, 1, 0, mv);
      chk(word_t'(p ? b_to_a_mail_waiting_n : a_to_b_mail_waiting_n), '0);
      op(p[0], 1, 1, 0, '0);
      op(!p[0], 0, 1, 1, '0);
      chk(p ? porta_data_bus_out : portb_data_bus_out, par(mv, 1'b1));
      chk(word_t'(p ? b_to_a_mail_waiting_n : a_to_b_mail_waiting_n), 1);
      chk(word_t'(p ? porta_parity_error_n : portb_parity_error_n), 1);
    end
    porta_parity_gen_on <= 1'b0;
    repeat (2) @(posedge clk);
    chk(word_t'(porta_parity_error_n), 36'h0);
    odd_parity_sense <= 1'b0;
    repeat (2) @(posedge clk);
    chk(word_t'(porta_parity_error_n), 36'h1);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
